/* design/irq_combiner_pkg.sv */
// package for the isa-side interrupt combining block: addresses, field layout, priorities.
// assumes an 8-bit isa i/o slave clocked by the isa bus clock.
// Function
// - answer as 8-bit isa i/o slave at exactly three byte addresses 804-806
// - select by decoding sa low three bits plus three extended decode bits
// - mask bit written one disables that source from the combined output
// - mask bit written zero enables that source into the combined output
// - reads return the raw live request inputs, never the masked result
// - a read bit of one means the source is asserting its request
// - mask registers are write-only; reads at their addresses show request status
// - byte 804: slot a lines 0-3, bridge, ide, reserved, slot b line 0
// - byte 805: slot b lines 1-3, slot c lines 0-3, slot d line 0
// - byte 806: slot d lines 1-3 in bits 0-2, bits 3-7 reserved
// - combined output ors enabled sources with bridge memory-error and error signals
// - combined pci/isa output drives cpu interrupt line 1, priority level 21
// - time-of-year clock interrupt goes out on cpu line 2, priority level 22
// - bridge memory-error and core-logic errors go out on machine check, level 31
// - corrected ecc and reserved sparse encodings go out on cpu line 0

package irq_combiner_pkg;

  // ******************************************
  // address decode
  // ******************************************
  localparam logic [11:0] ADDR_LOW    = 12'h804;
  localparam logic [11:0] ADDR_MID    = 12'h805;
  localparam logic [11:0] ADDR_HIGH   = 12'h806;
  localparam logic [2:0]  SA_LOW      = 3'h4;
  localparam logic [2:0]  SA_MID      = 3'h5;
  localparam logic [2:0]  SA_HIGH     = 3'h6;
  localparam logic [2:0]  EXT_MATCH   = 3'h4;
  localparam logic [1:0]  IDX_LOW     = 2'h0;
  localparam logic [1:0]  IDX_MID     = 2'h1;
  localparam logic [1:0]  IDX_HIGH    = 2'h2;

  // ******************************************
  // field layout and reset values
  // ******************************************
  localparam int          BYTE_W      = 8;
  localparam int          VEC_W       = 24;
  localparam logic [7:0]  VALID_LOW   = 8'hBF;
  localparam logic [7:0]  VALID_MID   = 8'hFF;
  localparam logic [7:0]  VALID_HIGH  = 8'h07;
  localparam logic [23:0] VALID_ALL   = {VALID_HIGH, VALID_MID, VALID_LOW};
  localparam logic [23:0] MASK_RESET  = VALID_ALL;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  // ******************************************
  // fixed processor priority levels of the outputs
  // ******************************************
  localparam int          LEVEL_PCI_ISA = 21;
  localparam int          LEVEL_TOY     = 22;
  localparam int          LEVEL_MCHK    = 31;

  // true when the low address bits and extended bits hit one of the three bytes
  function automatic logic addr_hit(input logic [2:0] sa, input logic [2:0] ext);
    addr_hit = (ext == EXT_MATCH) && ((sa == SA_LOW) || (sa == SA_MID) || (sa == SA_HIGH));
  endfunction

  // byte index of a decoded address
  function automatic logic [1:0] addr_index(input logic [2:0] sa);
    logic [1:0] idx;
    idx = IDX_LOW;
    if (sa == SA_MID)
    begin
      idx = IDX_MID;
    end
    else if (sa == SA_HIGH)
    begin
      idx = IDX_HIGH;
    end
    addr_index = idx;
  endfunction

  // select one byte of a 24-bit vector, reserved bits forced to zero
  function automatic logic [7:0] pick_byte(input logic [23:0] vec, input logic [1:0] idx);
    logic [23:0] v;
    v = vec & VALID_ALL;
    pick_byte = (idx == IDX_HIGH) ? v[23:16] : ((idx == IDX_MID) ? v[15:8] : v[7:0]);
  endfunction

endpackage

/* design/isa_addr_decode.sv */
// address decoder for the three interrupt bytes.
// assumes isa address and extended decode bits are stable while a strobe is low.
`timescale 1ns/1ps
`default_nettype none

module isa_addr_decode (
  input  wire logic [2:0] sa_in,
  input  wire logic [2:0] ext_addr_in,
  output logic            sel_out,
  output logic [1:0]      idx_out
);

  // ******************************************
  // decode
  // ******************************************
  // both halves of the address must match, otherwise the slave stays silent
  always_comb
  begin
    sel_out = irq_combiner_pkg::addr_hit(sa_in, ext_addr_in);
    idx_out = irq_combiner_pkg::addr_index(sa_in);
  end

endmodule

`default_nettype wire

/* design/irq_mask_bank.sv */
// three write-only mask bytes held as one 24-bit vector.
// assumes one write pulse per isa write strobe from the bus front end.
`timescale 1ns/1ps
`default_nettype none

module irq_mask_bank (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        wr_en_in,
  input  wire logic [1:0]  wr_idx_in,
  input  wire logic [7:0]  wr_data_in,
  output logic [23:0]      mask_out
);

  typedef struct packed {
    logic [23:0] mask;
  } bank_type;

  bank_type st_q;
  bank_type st_d;

  // ******************************************
  // next state
  // ******************************************
  // reserved positions keep their reset value, so writes there are dropped
  always_comb
  begin
    st_d = st_q;
    if (wr_en_in)
    begin
      unique case (wr_idx_in)
        irq_combiner_pkg::IDX_LOW:
          st_d.mask[7:0] = wr_data_in & irq_combiner_pkg::VALID_LOW;
        irq_combiner_pkg::IDX_MID:
          st_d.mask[15:8] = wr_data_in & irq_combiner_pkg::VALID_MID;
        irq_combiner_pkg::IDX_HIGH:
          st_d.mask[23:16] = wr_data_in & irq_combiner_pkg::VALID_HIGH;
        default:
          st_d.mask = st_q.mask;
      endcase
    end
  end

  // ******************************************
  // registers
  // ******************************************
  // all sources start masked so no source request fires before software sets up
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_q.mask <= irq_combiner_pkg::MASK_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign mask_out = st_q.mask;

endmodule

`default_nettype wire

/* design/irq_combiner.sv */
// interrupt combiner: isa i/o slave with three mask bytes and the cpu interrupt outputs.
// assumes isa strobes and all request inputs are synchronous to clk_in, active high requests.
`timescale 1ns/1ps
`default_nettype none

module irq_combiner (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // isa slave side
  input  wire logic [2:0] sa_in,
  input  wire logic [2:0] ext_addr_in,
  input  wire logic       ior_n_in,
  input  wire logic       iow_n_in,
  input  wire logic [7:0] sd_in,
  output logic [7:0]      sd_out,
  output logic            sd_oe_out,
  // request sources
  input  wire logic [3:0] slot_a_line_in,
  input  wire logic [3:0] slot_b_line_in,
  input  wire logic [3:0] slot_c_line_in,
  input  wire logic [3:0] slot_d_line_in,
  input  wire logic       bridge_irq_in,
  input  wire logic       ide_irq_in,
  input  wire logic       bridge_mem_err_in,
  input  wire logic       bridge_err_in,
  input  wire logic       core_err_in,
  input  wire logic       ecc_corrected_in,
  input  wire logic       sparse_rsvd_in,
  input  wire logic       time_of_year_clock_in,
  // processor side
  output logic            cpu_irq0_out,
  output logic            pci_isa_irq_out,
  output logic            cpu_irq2_out,
  output logic            mch_chk_out
);

  // ******************************************
  // types and state
  // ******************************************
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_READ  = 3'b010,
    BUS_WRITE = 3'b100
  } bus_type;

  typedef struct packed {
    bus_type    bus;
    logic [7:0] rd_data;
    logic       rd_oe;
    logic [1:0] rd_idx;
    logic       irq0;
    logic       pci_isa;
    logic       irq2;
    logic       mchk;
  } state_type;

  state_type   st_q;
  state_type   st_d;

  logic        sel_c;
  logic [1:0]  idx_c;
  logic [23:0] mask_c;
  logic [23:0] raw_c;
  logic [23:0] eff_c;
  logic        err_c;
  logic        rd_req_c;
  logic        wr_req_c;
  logic        wr_en_c;
  logic [7:0]  rd_byte_c;

  // ******************************************
  // address decode and mask storage
  // ******************************************
  isa_addr_decode u_decode (
    .sa_in       (sa_in),
    .ext_addr_in (ext_addr_in),
    .sel_out     (sel_c),
    .idx_out     (idx_c)
  );

  irq_mask_bank u_masks (
    .clk_in     (clk_in),
    .rstn_in    (rstn_in),
    .wr_en_in   (wr_en_c),
    .wr_idx_in  (idx_c),
    .wr_data_in (sd_in),
    .mask_out   (mask_c)
  );

  // ******************************************
  // request vector
  // ******************************************
  // raw vector laid out exactly as the three bytes, reserved bits zero
  always_comb
  begin
    raw_c = {5'h00, slot_d_line_in[3:1],
             slot_d_line_in[0], slot_c_line_in, slot_b_line_in[3:1],
             slot_b_line_in[0], 1'b0, ide_irq_in, bridge_irq_in, slot_a_line_in};
    eff_c = raw_c & ~mask_c & irq_combiner_pkg::VALID_ALL;
    err_c = bridge_mem_err_in | bridge_err_in;
    rd_byte_c = irq_combiner_pkg::pick_byte(raw_c, idx_c);
  end

  // strobes only count when the address is ours
  always_comb
  begin
    rd_req_c = !ior_n_in && sel_c;
    wr_req_c = !iow_n_in && sel_c;
    // a read strobe in the same cycle wins, matching the phase the machine enters
    wr_en_c  = wr_req_c && !rd_req_c && (st_q.bus == BUS_IDLE);
  end

  // ******************************************
  // next state
  // ******************************************
  // a strobe held low stays in its phase; read data track the live inputs while held
  always_comb
  begin
    st_d = st_q;
    st_d.rd_oe = 1'b0;
    st_d.rd_data = irq_combiner_pkg::BYTE_ZERO;
    unique case (st_q.bus)
      BUS_IDLE:
      begin
        if (rd_req_c)
        begin
          st_d.bus = BUS_READ;
          st_d.rd_oe = 1'b1;
          st_d.rd_data = rd_byte_c;
          st_d.rd_idx = idx_c;
        end
        else if (wr_req_c)
        begin
          st_d.bus = BUS_WRITE;
        end
      end
      BUS_READ:
      begin
        if (rd_req_c)
        begin
          st_d.rd_oe = 1'b1;
          st_d.rd_data = rd_byte_c;
          st_d.rd_idx = idx_c;
        end
        else
        begin
          st_d.bus = BUS_IDLE;
        end
      end
      BUS_WRITE:
      begin
        if (iow_n_in)
        begin
          st_d.bus = BUS_IDLE;
        end
      end
      default:
      begin
        st_d.bus = BUS_IDLE;
      end
    endcase
    // interrupt outputs are plain registered combinations, no latching
    st_d.pci_isa = (|eff_c) | err_c;
    st_d.irq2    = time_of_year_clock_in;
    st_d.mchk    = err_c | core_err_in;
    st_d.irq0    = ecc_corrected_in | sparse_rsvd_in;
  end

  // ******************************************
  // registers
  // ******************************************
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_q.bus     <= BUS_IDLE;
      st_q.rd_data <= irq_combiner_pkg::BYTE_ZERO;
      st_q.rd_oe   <= 1'b0;
      st_q.rd_idx  <= irq_combiner_pkg::IDX_LOW;
      st_q.irq0    <= 1'b0;
      st_q.pci_isa <= 1'b0;
      st_q.irq2    <= 1'b0;
      st_q.mchk    <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign sd_out          = st_q.rd_data;
  assign sd_oe_out       = st_q.rd_oe;
  assign cpu_irq0_out    = st_q.irq0;
  assign pci_isa_irq_out = st_q.pci_isa;
  assign cpu_irq2_out    = st_q.irq2;
  assign mch_chk_out     = st_q.mchk;

  // ******************************************
  // assertions
  // ******************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  read_data_live_a: assert property ((st_q.bus == BUS_IDLE && rd_req_c) |=>
    (sd_oe_out && sd_out == $past(rd_byte_c)))
    else $error("read byte does not match live requests");

  read_bit_set_a: assert property ((st_q.bus == BUS_IDLE && rd_req_c && idx_c == 2'h0
    && slot_a_line_in[0]) |=> sd_out[0])
    else $error("asserted request read as zero");

  reserved_zero_a: assert property (sd_oe_out |->
    ((sd_out & ~irq_combiner_pkg::pick_byte(irq_combiner_pkg::VALID_ALL, st_q.rd_idx))
     == irq_combiner_pkg::BYTE_ZERO))
    else $error("reserved read bit not zero");

  foreign_addr_a: assert property ((!ior_n_in && !sel_c) [*2] |-> !sd_oe_out)
    else $error("slave drove data for a foreign address");

  mask_write_a: assert property ((wr_en_c && idx_c == irq_combiner_pkg::IDX_MID) |=>
    mask_c[15:8] == $past(sd_in))
    else $error("mask byte not updated by write");

  single_write_a: assert property ((st_q.bus == BUS_WRITE) |-> !wr_en_c)
    else $error("second mask update in one write strobe");

  masked_quiet_a: assert property ((eff_c == 24'h000000 && !err_c) |=> !pci_isa_irq_out)
    else $error("combined output fired with all sources masked");

  enabled_fires_a: assert property ((|eff_c) |=> pci_isa_irq_out)
    else $error("enabled request did not reach combined output");

  error_route_a: assert property (err_c |=> (pci_isa_irq_out && mch_chk_out))
    else $error("bridge error not on combined and machine check");

  toy_route_a: assert property (cpu_irq2_out == $past(time_of_year_clock_in)
    || $past(!rstn_in))
    else $error("time-of-year request not on line 2");

  ecc_route_a: assert property ((ecc_corrected_in || sparse_rsvd_in) |=> cpu_irq0_out)
    else $error("corrected error not on line 0");

  // ******************************************
  // assertions on the quiet side of line 0 and machine check, plus the core error route
  // ******************************************
  // a check of the firing direction alone would miss an output stuck high
  line0_quiet_a: assert property ((!ecc_corrected_in && !sparse_rsvd_in) |=>
    !cpu_irq0_out)
    else $error("line 0 fired with no corrected error");

  mchk_quiet_a: assert property ((!err_c && !core_err_in) |=> !mch_chk_out)
    else $error("machine check fired with no error input");

  core_err_route_a: assert property (core_err_in |=> mch_chk_out)
    else $error("core logic error not on machine check");

  // ******************************************
  // assertions on the bus phases and mask storage
  // ******************************************
  // the slave must let go of the data lines one cycle after the strobe ends
  read_drop_a: assert property ((st_q.bus == BUS_READ && !rd_req_c) |=> !sd_oe_out)
    else $error("slave kept driving after read strobe ended");

  read_refresh_a: assert property ((st_q.bus == BUS_READ && rd_req_c) |=>
    (sd_oe_out && sd_out == $past(rd_byte_c)))
    else $error("held read does not follow live requests");

  write_no_drive_a: assert property ((st_q.bus == BUS_WRITE) |-> !sd_oe_out)
    else $error("slave drove data during a write");

  sd_idle_zero_a: assert property (!sd_oe_out |->
    (sd_out == irq_combiner_pkg::BYTE_ZERO))
    else $error("data lines not zero while not driving");

  read_phase_write_a: assert property ((st_q.bus == BUS_READ) |-> !wr_en_c)
    else $error("mask updated during a read phase");

  foreign_write_a: assert property ((!iow_n_in && !sel_c) |-> !wr_en_c)
    else $error("mask update for a foreign address");

  // only a selected write may move the masks; reserved positions never take a one
  mask_hold_a: assert property (!wr_en_c |=> $stable(mask_c))
    else $error("mask changed without a selected write");

  mask_low_write_a: assert property ((wr_en_c && idx_c == irq_combiner_pkg::IDX_LOW)
    |=> mask_c[7:0] == ($past(sd_in) & irq_combiner_pkg::VALID_LOW))
    else $error("low mask byte or its reserved bit wrong after write");

  mask_high_write_a: assert property ((wr_en_c && idx_c == irq_combiner_pkg::IDX_HIGH)
    |=> mask_c[23:16] == ($past(sd_in) & irq_combiner_pkg::VALID_HIGH))
    else $error("high mask byte or its reserved bits wrong after write");

  // ******************************************
  // cover points for the main scenarios
  // ******************************************
  read_cover: cover property ((st_q.bus == BUS_IDLE && rd_req_c) ##1 sd_oe_out [*2]);
  write_cover: cover property (wr_en_c ##1 (st_q.bus == BUS_WRITE) ##[1:8] iow_n_in);
  unmask_cover: cover property (wr_en_c ##1 (|eff_c) ##1 pci_isa_irq_out);
  error_cover: cover property (err_c ##1 (pci_isa_irq_out && mch_chk_out));
  foreign_cover: cover property ((!ior_n_in && !sel_c) [*2]);

endmodule

`default_nettype wire

/* test/isa_io_master.sv */
// isa bus master model: 8-bit i/o read and write cycles toward the combiner.
// assumes the bench calls its tasks; all lines change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module isa_io_master (
  input  wire logic       clk_in,
  input  wire logic [7:0] sd_rd_in,
  input  wire logic       sd_oe_in,
  output logic [2:0]      sa_out,
  output logic [2:0]      ext_addr_out,
  output logic            ior_n_out,
  output logic            iow_n_out,
  output logic [7:0]      sd_out
);
  // idle bus: both strobes high, data lines not left at a stale value
  initial
  begin
    sa_out       = 3'h0;
    ext_addr_out = 3'h0;
    ior_n_out    = 1'b1;
    iow_n_out    = 1'b1;
    sd_out       = 8'hA5;
  end

  // write: strobe low for one clock, then one idle clock before the next strobe
  task automatic io_write(input logic [2:0] sa, input logic [2:0] ext, input logic [7:0] data);
    @(negedge clk_in);
    sa_out       = sa;
    ext_addr_out = ext;
    sd_out       = data;
    iow_n_out    = 1'b0;
    @(negedge clk_in);
    iow_n_out    = 1'b1;
    sd_out       = ~data; // released data must not keep the last byte
    @(negedge clk_in);
  endtask

  // read: strobe held across the taken edge and the answer edge, then two idle clocks
  task automatic io_read(input logic [2:0] sa, input logic [2:0] ext,
                         output logic [7:0] data, output logic oe);
    @(negedge clk_in);
    sa_out       = sa;
    ext_addr_out = ext;
    ior_n_out    = 1'b0;
    @(negedge clk_in);
    @(negedge clk_in);
    data         = sd_rd_in;
    oe           = sd_oe_in;
    ior_n_out    = 1'b1;
    @(negedge clk_in);
    @(negedge clk_in);
  endtask
endmodule

`default_nettype wire

/* test/irq_combiner_tb_top.sv */
// testbench for the interrupt combiner: model of masks and requests checked at every result.
// assumes the isa master model and the design share one 20 mhz clock.
`timescale 1ns/1ps
`default_nettype none

module irq_combiner_tb_top;
  localparam logic [23:0] VALID = 24'h07FFBF; // reserved bits never read or combine
  logic        clk_in;
  logic        rstn_in;
  logic [2:0]  sa;
  logic [2:0]  ext;
  logic        ior_n;
  logic        iow_n;
  logic [7:0]  sd_wr;
  logic [7:0]  sd_rd;
  logic        sd_oe;
  logic [23:0] raw_q;
  logic [5:0]  side_q;
  logic [23:0] mask_m;
  logic [3:0]  outs;
  logic [31:0] seed;
  logic [31:0] r;
  int          n_mismatch;
  int          n_compared;
  int          cycles;

  // ******************************************
  // design, bus master and clock
  // ******************************************
  irq_combiner u_irq_combiner (
    .clk_in(clk_in), .rstn_in(rstn_in), .sa_in(sa), .ext_addr_in(ext),
    .ior_n_in(ior_n), .iow_n_in(iow_n), .sd_in(sd_wr), .sd_out(sd_rd), .sd_oe_out(sd_oe),
    .slot_a_line_in(raw_q[3:0]), .slot_b_line_in({raw_q[10:8], raw_q[7]}),
    .slot_c_line_in(raw_q[14:11]), .slot_d_line_in({raw_q[18:16], raw_q[15]}),
    .bridge_irq_in(raw_q[4]), .ide_irq_in(raw_q[5]), .bridge_mem_err_in(side_q[0]),
    .bridge_err_in(side_q[1]), .core_err_in(side_q[2]), .ecc_corrected_in(side_q[3]),
    .sparse_rsvd_in(side_q[4]), .time_of_year_clock_in(side_q[5]),
    .cpu_irq0_out(outs[0]), .pci_isa_irq_out(outs[1]), .cpu_irq2_out(outs[2]),
    .mch_chk_out(outs[3])
  );

  isa_io_master u_isa_io_master (
    .clk_in(clk_in), .sd_rd_in(sd_rd), .sd_oe_in(sd_oe), .sa_out(sa),
    .ext_addr_out(ext), .ior_n_out(ior_n), .iow_n_out(iow_n), .sd_out(sd_wr)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // hang guard: the whole run needs about 900 clocks
  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 8000)
    begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL %0t timeout", $time);
      complete_run();
    end
  end

  // ******************************************
  // model, comparisons and bus helpers
  // ******************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check_outs();
    logic [3:0] exp;
    exp[0] = side_q[3] | side_q[4];
    exp[1] = (|(raw_q & ~mask_m & VALID)) | side_q[0] | side_q[1];
    exp[2] = side_q[5];
    exp[3] = side_q[0] | side_q[1] | side_q[2];
    n_compared = n_compared + 1;
    if (outs !== exp)
      mismatch($sformatf("outputs got %h exp %h", outs, exp));
  endtask

  task automatic check_read(input logic [8:0] got, input logic [8:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
      mismatch($sformatf("read got %h exp %h", got, exp));
  endtask

  task automatic mismatch(input string msg);
    n_mismatch = n_mismatch + 1;
    $display("FAIL %0t %s", $time, msg);
  endtask

  task automatic wr_byte(input int idx, input logic [7:0] d);
    u_isa_io_master.io_write(3'(4 + idx), 3'h4, d);
    mask_m[idx*8 +: 8] = d;
  endtask

  // read one status byte: live requests with reserved bits zero, then bus released
  task automatic rd_check(input int idx);
    logic [7:0]  d;
    logic        oe;
    logic [23:0] exp;
    exp = raw_q & VALID;
    u_isa_io_master.io_read(3'(4 + idx), 3'h4, d, oe);
    check_read({oe, d}, {1'b1, exp[idx*8 +: 8]});
    check_read({sd_oe, sd_rd}, 9'h000);
  endtask

  task automatic settle();
    repeat (3) @(negedge clk_in);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ******************************************
  // main sequence
  // ******************************************
  initial
  begin
    logic [7:0] d;
    logic       oe;
    seed = 32'h92F7;
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    rstn_in = 1'b0;
    raw_q = 24'hFFFFFF;
    side_q = 6'h00;
    mask_m = 24'hFFFFFF;
    repeat (2) @(negedge clk_in);
    // cpu lines stay low in reset so the jumper levels own them
    check_outs();
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    settle();
    check_outs();
    $display("test reset_masked done");
    // one source at a time, all others masked: hits every byte position
    for (int i = 0; i < 24; i++)
    begin
      raw_q = 24'h000001 << i;
      for (int b = 0; b < 3; b++)
        wr_byte(b, ~raw_q[b*8 +: 8]);
      settle();
      check_outs();
      rd_check(i / 8);
    end
    $display("test single_source done");
    // random requests, side errors and mask bytes
    for (int i = 0; i < 40; i++)
    begin
      r = rnd();
      raw_q = r[23:0];
      side_q = r[29:24];
      if (r[30])
        wr_byte(int'(r[7:0]) % 3, 8'(rnd()));
      settle();
      check_outs();
      rd_check(int'(r[15:8]) % 3);
    end
    $display("test random_traffic done");
    // unmapped reads never drive, unmapped writes leave the masks alone
    side_q = 6'h00;
    for (int b = 0; b < 3; b++)
      wr_byte(b, 8'hFF);
    raw_q = 24'hFFFFFF;
    for (int k = 0; k < 8; k++)
    begin
      if (k < 4 || k == 7)
      begin
        u_isa_io_master.io_read(3'(k), 3'h4, d, oe);
        check_read({oe, d}, 9'h000);
        u_isa_io_master.io_write(3'(k), 3'h4, 8'h00);
      end
      if (k != 4)
      begin
        u_isa_io_master.io_read(3'h4, 3'(k), d, oe);
        check_read({oe, d}, 9'h000);
        u_isa_io_master.io_write(3'h5, 3'(k), 8'h00);
      end
    end
    settle();
    check_outs();
    $display("test unmapped done");
    complete_run();
  end
endmodule

`default_nettype wire
